// ### common/frac_mul_map.vh
// Constants for the fractional multiply unit: opcodes, flag position,
// saturation patterns and exception cause codes.
// Included by the design files; holds definitions only.
`ifndef FRAC_MUL_MAP_VH
`define FRAC_MUL_MAP_VH
`define OP_NONE          2'h0
`define OP_ROUNDED_WORD  2'h1
`define OP_PACKED_HALF   2'h2
`define OP_TRUNC_WORD    2'h3
`define OVF_FLAG_BIT     21
`define CTRL_RESET       32'h0000_0000
`define WORD_MIN         32'h8000_0000
`define WORD_MAX         32'h7FFF_FFFF
`define HALF_MIN         16'h8000
`define HALF_MAX         16'h7FFF
`define ROUND_ADD        64'h0000_0000_8000_0000
`define EXC_NONE         2'h0
`define EXC_RESERVED     2'h1
`define EXC_DISABLED     2'h2
`endif

// ### rtl/q15_lane_mul.v
// One Q15 fractional multiply lane with saturation on -1 times -1.
// Purely combinational; the parent registers the result.
`timescale 1ns/1ns
`default_nettype none
`include "frac_mul_map.vh"
module q15_lane_mul (
  input  wire [15:0] laneA,    // First Q15 operand.
  input  wire [15:0] laneB,    // Second Q15 operand.
  output wire [15:0] laneOut,  // Q15 result.
  output wire        laneSat   // Lane saturated.
);
  wire signed [31:0] product;
  wire        [31:0] shifted;
  assign product = $signed(laneA) * $signed(laneB);
  assign shifted = {product[30:0], 1'b0};
  assign laneSat = (laneA == `HALF_MIN) && (laneB == `HALF_MIN);
  assign laneOut = laneSat ? `HALF_MAX : shifted[31:16];
endmodule // q15_lane_mul
`default_nettype wire

// ### rtl/frac_q31_q15_mul.v
// Fractional multiply unit for the rounded word, packed halfword and
// truncated word instructions, with sticky overflow flag bit 21.
// Assumes the pipeline holds issue valid for one cycle per instruction.
`timescale 1ns/1ns
`default_nettype none
`include "frac_mul_map.vh"
// Notes on behaviour
// - Rounded word: signed product shifted left one gives 64-bit value.
// - Rounded word: add one at bit 31, keep the upper 32 bits.
// - Rounded word: both sources 0x80000000 give 0x7FFFFFFF, no rounding.
// - Any saturation, either lane included, sets overflow flag bit 21.
// - Accumulator zero may be clobbered; accumulators one to three kept.
// - Packed half: each lane product shifted left one, low 16 dropped.
// - Packed half: lane with both inputs 0x8000 yields 0x7FFF.
// - Packed half: upper-lane result goes to upper destination half.
// - Truncated word: product shifted left one, upper word, no round.
// - Truncated word: both sources 0x80000000 give 0x7FFFFFFF.
// - No exception from operand values; saturation only sets the flag.
// - Only reserved-instruction and module-disabled exceptions arise.
module frac_q31_q15_mul (
  input  wire        clk,          // Core clock.
  input  wire        rst_n,        // Synchronous reset, active low.
  input  wire        issueValid,   // Instruction issued this cycle.
  input  wire [1:0]  opSel,        // Which multiply.
  input  wire [31:0] srcA,         // First source register value.
  input  wire [31:0] srcB,         // Second source register value.
  input  wire        extPresent,   // Extension is implemented.
  input  wire        extEnabled,   // Extension is turned on.
  input  wire        ctrlWrite,    // Pipeline writes the control register.
  input  wire [31:0] ctrlWrData,   // Value for that write.
  output reg         resultValid,  // Destination value valid, one cycle.
  output reg  [31:0] resultData,   // Destination register value.
  output reg         excValid,     // Exception raised, one cycle.
  output reg  [1:0]  excCause,     // Exception cause code.
  output reg         acc0Clobber,  // Accumulator zero now unpredictable.
  output reg  [31:0] ctrlValue     // Module control register contents.
);
  function [31:0] wordMul;
    input [31:0] a;
    input [31:0] b;
    input        doRound;
    reg   [63:0] prod;
    begin
      prod = $signed(a) * $signed(b);
      prod = {prod[62:0], 1'b0};
      if (doRound) begin
        prod = prod + `ROUND_ADD;
      end
      wordMul = prod[63:32];
    end
  endfunction

  wire        wordSat;
  wire [15:0] hiLane;
  wire [15:0] loLane;
  wire        hiSat;
  wire        loSat;
  reg  [31:0] resNext;
  reg         satNext;
  reg  [31:0] ctrl_reg;
  reg  [31:0] ctrl_next;
  wire        known;
  wire        execOk;
  wire        taken;
  wire [31:0] roundWord;
  wire [31:0] truncWord;
  wire [31:0] packedWord;
  wire        packedSat;
  reg         validNext;
  reg  [31:0] dataNext;
  reg         excNext;
  reg  [1:0]  causeNext;
  reg         clobNext;

  // Absence outranks disablement, so a core without the extension never
  // reports it as merely switched off.
  function [1:0] causeOf;
    input present;
    input enabled;
    begin
      if (!present) begin
        causeOf = `EXC_RESERVED;
      end else if (!enabled) begin
        causeOf = `EXC_DISABLED;
      end else begin
        causeOf = `EXC_NONE;
      end
    end
  endfunction

  assign wordSat = (srcA == `WORD_MIN) && (srcB == `WORD_MIN);

  // Both word forms are built side by side; the opcode picks one. This
  // costs a second multiplier but keeps the select out of the carry path.
  assign roundWord = wordMul(srcA, srcB, 1'b1);
  assign truncWord = wordMul(srcA, srcB, 1'b0);

  q15_lane_mul upperLane (
    .laneA   (srcA[31:16]),
    .laneB   (srcB[31:16]),
    .laneOut (hiLane),
    .laneSat (hiSat)
  );
  q15_lane_mul lowerLane (
    .laneA   (srcA[15:0]),
    .laneB   (srcB[15:0]),
    .laneOut (loLane),
    .laneSat (loSat)
  );

  assign packedWord = {hiLane, loLane};
  assign packedSat  = hiSat | loSat;

  always @* begin
    resNext = 32'h0000_0000;
    satNext = 1'b0;
    case (opSel)
      `OP_ROUNDED_WORD: begin
        satNext = wordSat;
        resNext = wordSat ? `WORD_MAX : roundWord;
      end
      `OP_PACKED_HALF: begin
        satNext = packedSat;
        resNext = packedWord;
      end
      `OP_TRUNC_WORD: begin
        satNext = wordSat;
        resNext = wordSat ? `WORD_MAX : truncWord;
      end
      default: begin
        resNext = 32'h0000_0000;
        satNext = 1'b0;
      end
    endcase
  end

  assign known  = (opSel != `OP_NONE);
  assign taken  = issueValid && known;
  // Operand values never trap; only presence and enable decide.
  assign execOk = taken && extPresent && extEnabled;

  // An explicit pipeline write loses to a same-cycle saturation on bit 21,
  // so a saturation event is never dropped.
  always @* begin
    ctrl_next = ctrl_reg;
    if (ctrlWrite) begin
      ctrl_next = ctrlWrData;
    end
    if (execOk && satNext) begin
      ctrl_next[`OVF_FLAG_BIT] = 1'b1;
    end
  end

  // The result word holds between instructions; pulses last one cycle.
  always @* begin
    validNext = execOk;
    clobNext  = execOk;
    dataNext  = resultData;
    excNext   = 1'b0;
    causeNext = `EXC_NONE;
    if (execOk) begin
      dataNext = resNext;
    end
    if (taken && !(extPresent && extEnabled)) begin
      excNext   = 1'b1;
      causeNext = causeOf(extPresent, extEnabled);
    end
  end

  // Accumulators one to three are not touched by this unit; only the
  // clobber pulse for accumulator zero leaves it.
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg    <= `CTRL_RESET;
      resultValid <= 1'b0;
      resultData  <= 32'h0000_0000;
      excValid    <= 1'b0;
      excCause    <= `EXC_NONE;
      acc0Clobber <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      resultValid <= validNext;
      resultData  <= dataNext;
      excValid    <= excNext;
      excCause    <= causeNext;
      acc0Clobber <= clobNext;
    end
  end

  always @* begin
    ctrlValue = ctrl_reg;
  end
endmodule // frac_q31_q15_mul
`default_nettype wire

// ### sim/frac_mul_properties.sv
// Checker for the fractional multiply unit, seeing only its ports.
// Assumes answers land one cycle after the taking edge.
`timescale 1ns/1ns
`default_nettype none
module frac_mul_properties (
  input wire logic        clk, rst_n, issueValid, extPresent, extEnabled,
  input wire logic        ctrlWrite, resultValid, excValid, acc0Clobber,
  input wire logic [1:0]  opSel, excCause,
  input wire logic [31:0] srcA, srcB, resultData, ctrlValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic tk = issueValid && opSel != 2'h0;
  wire logic go = tk && extPresent && extEnabled;
  wire logic wm = srcA == 32'h8000_0000 && srcB == 32'h8000_0000;
  wire logic hm = srcA[31:16] == 16'h8000 && srcB[31:16] == 16'h8000;
  wire logic lm = srcA[15:0] == 16'h8000 && srcB[15:0] == 16'h8000;
  wire logic nop = issueValid && opSel == 2'h0;
  answer_pair_a: assert property (
    go |=> resultValid && acc0Clobber && !excValid)
    else $error("bad answer");
  round_sat_a: assert property (
    go && opSel == 2'h1 && wm |=> resultData == 32'h7FFF_FFFF)
    else $error("bad rounded clip");
  trunc_sat_a: assert property (
    go && opSel == 2'h3 && wm |=> resultData == 32'h7FFF_FFFF)
    else $error("bad truncated clip");
  lane_sat_a: assert property (
    go && opSel == 2'h2 && hm |=> resultData[31:16] == 16'h7FFF)
    else $error("bad lane clip");
  low_lane_sat_a: assert property (
    go && opSel == 2'h2 && lm |=> resultData[15:0] == 16'h7FFF)
    else $error("bad low lane clip");
  flag_set_a: assert property (
    go && (opSel == 2'h2 ? hm || lm : wm) |=> ctrlValue[21])
    else $error("flag not set");
  flag_sticky_a: assert property (
    ctrlValue[21] && !ctrlWrite |=> ctrlValue[21])
    else $error("flag cleared");
  absent_trap_a: assert property (
    tk && !extPresent |=> excValid && excCause == 2'h1 && !resultValid)
    else $error("bad absent trap");
  off_trap_a: assert property (
    tk && extPresent && !extEnabled |=> excValid && excCause == 2'h2)
    else $error("bad disabled trap");
  idle_quiet_a: assert property (
    nop |=> !resultValid && !excValid && !acc0Clobber)
    else $error("answer to no-op");
  cover property (go && opSel == 2'h1 && wm);
  cover property (go && opSel == 2'h2 && hm);
  cover property (go && opSel == 2'h2 && lm);
  cover property (tk && !extPresent);
endmodule // frac_mul_properties
bind frac_q31_q15_mul frac_mul_properties chk (.*);
`default_nettype wire

// ### sim/issue_stage.sv
// Pipeline model that hands operands and control writes to the unit.
// Assumes callers return past an edge before calling again.
`timescale 1ns/1ns
`default_nettype none
module issue_stage (
  input  wire logic        clk,         // Core clock.
  output var  logic        issueValid,  // Issue strobe.
  output var  logic [1:0]  opSel,       // Multiply kind.
  output var  logic [31:0] srcA,        // First operand.
  output var  logic [31:0] srcB,        // Second operand.
  output var  logic        ctrlWrite,   // Control write.
  output var  logic [31:0] ctrlWrData   // Control value.
);
  initial {issueValid, opSel, srcA, srcB, ctrlWrite, ctrlWrData} = '0;
  // This pipeline keeps nothing in accumulator zero across a multiply,
  // so it has nothing to save or restore around one.
  // Operands flip once released so a stale value never looks held.
  task automatic issue(input logic [1:0] op, input logic [31:0] a, b);
    @(posedge clk) {issueValid, opSel, srcA, srcB} <= {1'b1, op, a, b};
    @(posedge clk) {issueValid, srcA, srcB} <= {1'b0, ~a, ~b};
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge clk) {ctrlWrite, ctrlWrData} <= {1'b1, d};
    @(posedge clk) ctrlWrite <= 1'b0;
  endtask
endmodule // issue_stage
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the fractional multiply unit.
// Assumes outputs settle within one cycle of the taking edge.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("Error %0t got %h want %h", $time, a, e); end end
module tb_top;
  logic clk = 0, rst_n = 0, extPresent = 1, extEnabled = 1, fl = 0;
  logic issueValid, ctrlWrite, resultValid, excValid, acc0Clobber;
  logic [1:0] opSel, excCause;
  logic [31:0] srcA, srcB, ctrlWrData, resultData, ctrlValue;
  int errors = 0, checks_done = 0;
  issue_stage P (.*);
  frac_q31_q15_mul DUT (.*);
  initial forever #5 clk = ~clk;
  function automatic logic [32:0] ex(input logic [1:0] op,
                                     input logic [31:0] a, b);
    logic signed [63:0] p;
    logic signed [31:0] h;
    logic signed [31:0] l;
    logic        [63:0] t;
    logic               sw;
    logic               sh;
    logic               sl;
    p = $signed(a) * $signed(b);
    h = $signed(a[31:16]) * $signed(b[31:16]);
    l = $signed(a[15:0]) * $signed(b[15:0]);
    sw = a == 32'h8000_0000 && b == 32'h8000_0000;
    sh = a[31:16] == 16'h8000 && b[31:16] == 16'h8000;
    sl = a[15:0] == 16'h8000 && b[15:0] == 16'h8000;
    h = sh ? 32'h7FFF_0000 : h <<< 1;
    l = sl ? 32'h7FFF_0000 : l <<< 1;
    t = (p <<< 1) + (op == 2'h1 ? 64'h0000_0000_8000_0000 : 64'h0);
    if (op == 2'h2) return {sh | sl, h[31:16], l[31:16]};
    return {sw, sw ? 32'h7FFF_FFFF : t[63:32]};
  endfunction
  task automatic run(input logic [1:0] op, input logic [31:0] a, b);
    logic [32:0] e;
    e = ex(op, a, b);
    fl = fl | e[32];
    P.issue(op, a, b);
    #1;
    `CHK({resultValid, acc0Clobber, excValid}, 3'b110)
    `CHK(resultData, e[31:0])
    `CHK(ctrlValue[21], fl)
  endtask
  task automatic t_exc;
    logic [3:0] w;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) {extPresent, extEnabled} <= k == 0 ? 2'b01 : 2'b10;
      if (k == 2) break;
      w = {1'b1, k ? 2'h2 : 2'h1, 1'b0};
      P.issue(2'h1, 32'h8000_0000, 32'h8000_0000);
      #1;
      `CHK({excValid, excCause, resultValid}, w)
      `CHK(ctrlValue[21], 1'b0)
    end
    @(posedge clk) {extPresent, extEnabled} <= 2'b11;
  endtask
  task automatic t_words;
    for (int op = 1; op < 4; op += 2) begin
      run(op[1:0], 32'h1234_5678, 32'h9ABC_DEF0);
      run(op[1:0], 32'h8000_0000, 32'h8000_0000);
      run(op[1:0], 32'hC000_0001, 32'h0000_7FFF);
    end
  endtask
  task automatic t_packed;
    P.wr(32'h0000_0000);
    fl = 0;
    run(2'h2, 32'h4000_8000, 32'hC000_7000);
    run(2'h2, 32'h8000_1234, 32'h8000_8765);
    P.wr(32'h0000_0000);
    fl = 0;
    run(2'h2, 32'h1234_8000, 32'h5678_8000);
  endtask
  task automatic t_refuse;
    P.issue(2'h0, 32'h8000_0000, 32'h8000_0000);
    #1;
    `CHK({resultValid, excValid, acc0Clobber}, 3'b000)
    `CHK(ctrlValue[21], fl)
  endtask
  // A control write that meets a saturation in one cycle must not lose it.
  task automatic t_clash;
    fork
      P.wr(32'h0000_0000);
      P.issue(2'h3, 32'h8000_0000, 32'h8000_0000);
    join
    #1;
    `CHK(ctrlValue[21], 1'b1)
    `CHK(resultData, 32'h7FFF_FFFF)
    fl = 1;
  endtask
  task automatic summarize;
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_exc;
    t_words;
    t_packed;
    t_refuse;
    t_clash;
    summarize;
  end
endmodule // tb_top
`default_nettype wire
